//--- hw/cfg_word_reg.sv
// One 16-bit configuration word with its own reset value
`timescale 1ns/100ps
`default_nettype none
module cfg_word_reg
  import synth_cfg_pkg::*;
#(
  parameter reg_word_t RESET_VAL = 16'h0000
) (
  input  wire logic      i_clk,
  input  wire logic      i_reset,
  input  wire logic      i_wr_en,
  input  wire reg_word_t i_wr_data,
  output var  reg_word_t o_q
);
  // Held word
  reg_word_t q_r;
  reg_word_t q_nxt;

  // Keeps the word until the next write or reset
  always_comb
  begin
    q_nxt = q_r;
    if (i_wr_en)
    begin
      q_nxt = i_wr_data;
    end
  end

  // Register stage
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      q_r <= RESET_VAL;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule
`default_nettype wire

//--- hw/serial_frame_port.sv
// Serial programming port: 24-bit frames, write commit and readback
`timescale 1ns/100ps
`default_nettype none
module serial_frame_port
  import synth_cfg_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_reset,
  input  wire logic      i_sck,
  input  wire logic      i_cs_n,
  input  wire logic      i_sdi,
  input  wire reg_word_t i_rd_data,
  output var  reg_addr_t o_addr,
  output var  logic      o_wr_stb,
  output var  reg_word_t o_wr_data,
  output var  logic      o_sdo
);
  `include "synth_cfg_params.svh"
  port_s s_r;
  port_s s_nxt;
  logic  rise;        // Serial clock rising edge
  logic  fall;        // Serial clock falling edge

  // Frame decoding; sck is sampled, so it must be well below i_clk/4
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.sck_q  = i_sck;
    s_nxt.wr_stb = 1'b0;
    s_nxt.load   = 1'b0;
    rise         = i_sck & ~s_r.sck_q;
    fall         = ~i_sck & s_r.sck_q;
    case (s_r.phase)
      PH_IDLE:
      begin
        s_nxt.cnt = 5'd0;
        s_nxt.sdo = 1'b0;
        if (!i_cs_n)
        begin
          s_nxt.phase = PH_HEAD;
        end
      end
      PH_HEAD:
      begin
        if (i_cs_n)
        begin
          s_nxt.phase = PH_IDLE;  // Short frame dropped
        end
        else if (rise)
        begin
          s_nxt.sh  = {s_r.sh[14:0], i_sdi};
          s_nxt.cnt = s_r.cnt + 5'd1;
          if (s_r.cnt == `HEAD_LAST)
          begin
            s_nxt.rd    = s_r.sh[6];
            s_nxt.addr  = {s_r.sh[5:0], i_sdi};
            s_nxt.load  = 1'b1;
            s_nxt.phase = PH_DATA;
          end
        end
      end
      PH_DATA:
      begin
        if (s_r.load)
        begin
          s_nxt.tx = i_rd_data;   // Snapshot for readback
        end
        if (i_cs_n)
        begin
          // Commit only complete write frames
          if (s_r.cnt == `FRAME_BITS && !s_r.rd)
          begin
            s_nxt.wr_stb  = 1'b1;
            s_nxt.wr_data = s_r.sh;
          end
          s_nxt.phase = PH_IDLE;
        end
        else
        begin
          // Bits past the 24th are ignored
          if (rise && s_r.cnt != `FRAME_BITS)
          begin
            s_nxt.sh  = {s_r.sh[14:0], i_sdi};
            s_nxt.cnt = s_r.cnt + 5'd1;
          end
          if (fall && s_r.rd)
          begin
            s_nxt.sdo = s_r.tx[15];
            s_nxt.tx  = {s_r.tx[14:0], 1'b0};
          end
        end
      end
      default:
      begin
        s_nxt.phase = PH_IDLE;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_r       <= '0;
      s_r.phase <= PH_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_addr    = s_r.addr;
  assign o_wr_stb  = s_r.wr_stb;
  assign o_wr_data = s_r.wr_data;
  assign o_sdo     = s_r.sdo;
endmodule
`default_nettype wire

//--- hw/synth_cfg_params.svh
// Register offsets, field positions, reset values and frame sizes
`ifndef SYNTH_CFG_PARAMS_SVH
`define SYNTH_CFG_PARAMS_SVH
// Serial frame: read flag, 7-bit address, 16-bit data
`define FRAME_BITS      5'd24
`define HEAD_LAST       5'd7
// Register offsets
`define OFS_MAIN_CTRL   7'h00
`define OFS_VCO_OVR     7'h08
`define OFS_REF_PATH    7'h09
`define OFS_REF_REF_MULTIPLIER    7'h0A
`define OFS_POST_DIV    7'h0B
`define OFS_PRE_DIV     7'h0C
`define OFS_PUMP_DET    7'h0D
`define OFS_AMP_VALUE   7'h13
// Reset values
`define RST_MAIN_CTRL   16'h001C
`define RST_VCO_OVR     16'h0000
`define RST_REF_PATH    16'h0200
`define RST_REF_REF_MULTIPLIER    16'h0080
`define RST_POST_DIV    16'h0010
`define RST_PRE_DIV     16'h0001
`define RST_PUMP_DET    16'h4000
`define RST_AMP_VALUE   16'h0960
// Field positions
`define BIT_FREQ_CAL_ENABLE     3
`define BIT_AMP_CAL_ENABLE     4
`define BIT_AMP_OVR     13
`define BIT_CAP_OVR     10
`define BIT_DOUBLER     11
`define BIT_REF_EN      9
`define REF_MULTIPLIER_MSB        11
`define REF_MULTIPLIER_LSB        7
`define POST_MSB        11
`define POST_LSB        4
`define PRE_MSB         11
`define PRE_LSB         0
`define BIT_PUMP_EN     14
`define DET_MSB         1
`define DET_LSB         0
`define AMPV_MSB        11
`define AMPV_LSB        3
`endif

//--- hw/synth_cfg_pkg.sv
// Types shared by the synthesizer configuration register bank
package synth_cfg_pkg;
  // Serial frame phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HEAD = 3'b010,
    PH_DATA = 3'b100
  } frame_phase_e;
  typedef logic [15:0] reg_word_t;
  typedef logic [6:0]  reg_addr_t;
  // Serial port state
  typedef struct packed {
    logic         sck_q;
    frame_phase_e phase;
    logic [4:0]   cnt;
    reg_word_t    sh;
    logic         rd;
    reg_addr_t    addr;
    logic         load;
    reg_word_t    tx;
    logic         sdo;
    logic         wr_stb;
    reg_word_t    wr_data;
  } port_s;
  // Output control levels
  typedef struct packed {
    logic        amp_override;
    logic        amp_cal_run;
    logic [8:0]  amp_value;
    logic        cap_override;
    logic        fcal_enable;
    logic        fcal_start;
    logic        doubler;
    logic        ref_en;
    logic [4:0]  ref_multiplier;
    logic [7:0]  post_div;
    logic [11:0] pre_div;
    logic        pump_en;
    logic [1:0]  det_mode;
  } ctrl_s;
endpackage

//--- hw/synth_ref_path_vco_override_regs.sv
// Synthesizer reference path, VCO override and charge pump register bank
// Notes on behaviour
// - Amplitude override bypasses automatic amplitude calibration
// - Cap-bank override skips frequency calibration
// - Doubler bit enables reference doubler, reset 0
// - Reference path enable bit, reset 1
// - Multiplier factor field; host keeps frequencies legal
// - Post-multiplier divider field, resets to 1
// - Pre-multiplier divider field, resets to 1
// - Pump enable bit drives the charge pump
// - Detector mode: 0 dual, 3 single
// - Writing frequency calibration bit launches calibration
// - Amplitude calibration enable bit
// - Amplitude value field, reset 300
`timescale 1ns/100ps
`default_nettype none
module synth_ref_path_vco_override_regs
  import synth_cfg_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  input  wire logic  i_sck,
  input  wire logic  i_cs_n,
  input  wire logic  i_sdi,
  output var  logic  o_sdo,
  output var  logic  o_vco_amp_override,
  output var  logic  o_amp_cal_run,
  output var  logic [8:0] o_vco_amp_value,
  output var  logic  o_cap_bank_override,
  output var  logic  o_freq_cal_enable,
  output var  logic  o_freq_cal_start,
  output var  logic  o_ref_doubler_enable,
  output var  logic  o_ref_path_enable,
  output var  logic [4:0] o_ref_multiplier,
  output var  logic [7:0] o_post_div,
  output var  logic [11:0] o_pre_div,
  output var  logic  o_pump_enable,
  output var  logic [1:0] o_detector_mode_sel
);
  `include "synth_cfg_params.svh"

  // Word indices into the bank
  localparam int NREG    = 8;
  localparam int IX_MAIN = 0;
  localparam int IX_VCO  = 1;
  localparam int IX_REF  = 2;
  localparam int IX_REF_MULTIPLIER = 3;
  localparam int IX_POST = 4;
  localparam int IX_PRE  = 5;
  localparam int IX_PUMP = 6;
  localparam int IX_AMP  = 7;
  // Offsets and reset words, in index order
  localparam reg_addr_t OFS [NREG] = '{`OFS_MAIN_CTRL, `OFS_VCO_OVR,
    `OFS_REF_PATH, `OFS_REF_REF_MULTIPLIER, `OFS_POST_DIV, `OFS_PRE_DIV,
    `OFS_PUMP_DET, `OFS_AMP_VALUE};
  localparam reg_word_t RST [NREG] = '{`RST_MAIN_CTRL, `RST_VCO_OVR,
    `RST_REF_PATH, `RST_REF_REF_MULTIPLIER, `RST_POST_DIV, `RST_PRE_DIV,
    `RST_PUMP_DET, `RST_AMP_VALUE};
  // Output levels as they stand after reset
  localparam ctrl_s CTRL_RST = '{
    amp_override : RST[IX_VCO][`BIT_AMP_OVR],
    amp_cal_run  : RST[IX_MAIN][`BIT_AMP_CAL_ENABLE] & ~RST[IX_VCO][`BIT_AMP_OVR],
    amp_value    : RST[IX_AMP][`AMPV_MSB:`AMPV_LSB],
    cap_override : RST[IX_VCO][`BIT_CAP_OVR],
    fcal_enable  : RST[IX_MAIN][`BIT_FREQ_CAL_ENABLE],
    fcal_start   : 1'b0,
    doubler      : RST[IX_REF][`BIT_DOUBLER],
    ref_en       : RST[IX_REF][`BIT_REF_EN],
    ref_multiplier         : RST[IX_REF_MULTIPLIER][`REF_MULTIPLIER_MSB:`REF_MULTIPLIER_LSB],
    post_div     : RST[IX_POST][`POST_MSB:`POST_LSB],
    pre_div      : RST[IX_PRE][`PRE_MSB:`PRE_LSB],
    pump_en      : RST[IX_PUMP][`BIT_PUMP_EN],
    det_mode     : RST[IX_PUMP][`DET_MSB:`DET_LSB]
  };

  reg_addr_t addr;            // Frame address, live after header
  logic      wr_stb;          // One-cycle commit of a write frame
  reg_word_t wr_data;         // Committed data word
  reg_word_t rd_data;         // Readback word for current address
  reg_word_t q [NREG];        // Held register words
  ctrl_s     s_r;             // Output flops
  ctrl_s     s_nxt;

  // Serial programming port
  serial_frame_port u_port (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_sck     (i_sck),
    .i_cs_n    (i_cs_n),
    .i_sdi     (i_sdi),
    .i_rd_data (rd_data),
    .o_addr    (addr),
    .o_wr_stb  (wr_stb),
    .o_wr_data (wr_data),
    .o_sdo     (o_sdo)
  );

  // One held word per offset
  for (genvar g = 0; g < NREG; g++)
  begin : g_word
    cfg_word_reg #(
      .RESET_VAL (RST[g])
    ) u_word (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_wr_en   (wr_stb && addr == OFS[g]),
      .i_wr_data (wr_data),
      .o_q       (q[g])
    );
  end

  // Readback decode; unmapped offsets read as zero
  always_comb
  begin
    rd_data = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (addr == OFS[i])
      begin
        rd_data = q[i];
      end
    end
  end

  // Control levels derived from the held words
  always_comb
  begin
    s_nxt = s_r;
    // Override takes amplitude from the value field, not calibration
    s_nxt.amp_override = q[IX_VCO][`BIT_AMP_OVR];
    s_nxt.amp_cal_run  = q[IX_MAIN][`BIT_AMP_CAL_ENABLE]
                       & ~q[IX_VCO][`BIT_AMP_OVR];
    s_nxt.amp_value    = q[IX_AMP][`AMPV_MSB:`AMPV_LSB];
    s_nxt.cap_override = q[IX_VCO][`BIT_CAP_OVR];
    s_nxt.fcal_enable  = q[IX_MAIN][`BIT_FREQ_CAL_ENABLE];
    // Launch only on a write of 1 and never under cap-bank override
    s_nxt.fcal_start   = wr_stb && addr == `OFS_MAIN_CTRL
                       && wr_data[`BIT_FREQ_CAL_ENABLE]
                       && !q[IX_VCO][`BIT_CAP_OVR];
    s_nxt.doubler      = q[IX_REF][`BIT_DOUBLER];
    s_nxt.ref_en       = q[IX_REF][`BIT_REF_EN];
    // Range of the product is the host's concern
    s_nxt.ref_multiplier         = q[IX_REF_MULTIPLIER][`REF_MULTIPLIER_MSB:`REF_MULTIPLIER_LSB];
    s_nxt.post_div     = q[IX_POST][`POST_MSB:`POST_LSB];
    s_nxt.pre_div      = q[IX_PRE][`PRE_MSB:`PRE_LSB];
    s_nxt.pump_en      = q[IX_PUMP][`BIT_PUMP_EN];
    s_nxt.det_mode     = q[IX_PUMP][`DET_MSB:`DET_LSB];
  end

  // Output register stage
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_r <= CTRL_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_vco_amp_override   = s_r.amp_override;
  assign o_amp_cal_run        = s_r.amp_cal_run;
  assign o_vco_amp_value      = s_r.amp_value;
  assign o_cap_bank_override  = s_r.cap_override;
  assign o_freq_cal_enable    = s_r.fcal_enable;
  assign o_freq_cal_start     = s_r.fcal_start;
  assign o_ref_doubler_enable = s_r.doubler;
  assign o_ref_path_enable    = s_r.ref_en;
  assign o_ref_multiplier     = s_r.ref_multiplier;
  assign o_post_div           = s_r.post_div;
  assign o_pre_div            = s_r.pre_div;
  assign o_pump_enable        = s_r.pump_en;
  assign o_detector_mode_sel  = s_r.det_mode;

  // Checks, all in the one clock domain
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Commit of a write frame to a given offset
  sequence s_wr(reg_addr_t a);
    wr_stb && addr == a;
  endsequence
  // Output settles two edges after commit
  sequence s_settle;
    ##2 1'b1;
  endsequence

  // Commit sequences are joined to their conditions by a zero delay
  AST_AMP_OVR_BYPASS: assert property (
    s_wr(`OFS_VCO_OVR) ##0 wr_data[`BIT_AMP_OVR] |-> s_settle
      ##0 (o_vco_amp_override && !o_amp_cal_run))
    else $error("amplitude override did not bypass calibration");
  AST_CAP_OVR_SKIP: assert property (
    s_wr(`OFS_MAIN_CTRL) ##0 wr_data[`BIT_FREQ_CAL_ENABLE]
      && q[IX_VCO][`BIT_CAP_OVR] |=> !o_freq_cal_start)
    else $error("calibration launched under cap-bank override");
  AST_FCAL_PULSE: assert property (
    s_wr(`OFS_MAIN_CTRL) ##0 wr_data[`BIT_FREQ_CAL_ENABLE]
      && !q[IX_VCO][`BIT_CAP_OVR]
      |=> o_freq_cal_start ##1 !o_freq_cal_start)
    else $error("calibration start not a single pulse");
  AST_DOUBLER: assert property (
    s_wr(`OFS_REF_PATH) |-> s_settle
      ##0 o_ref_doubler_enable == $past(wr_data[`BIT_DOUBLER], 2))
    else $error("doubler level does not follow write");
  AST_REF_EN: assert property (
    s_wr(`OFS_REF_PATH) |-> s_settle
      ##0 o_ref_path_enable == $past(wr_data[`BIT_REF_EN], 2))
    else $error("reference enable does not follow write");
  AST_REF_MULTIPLIER: assert property (
    s_wr(`OFS_REF_REF_MULTIPLIER) |-> s_settle
      ##0 o_ref_multiplier == $past(wr_data[`REF_MULTIPLIER_MSB:`REF_MULTIPLIER_LSB], 2))
    else $error("multiplier does not follow write");
  AST_POST_DIV: assert property (
    s_wr(`OFS_POST_DIV) |-> s_settle
      ##0 o_post_div == $past(wr_data[`POST_MSB:`POST_LSB], 2))
    else $error("post divider does not follow write");
  AST_PRE_DIV: assert property (
    s_wr(`OFS_PRE_DIV) |-> s_settle
      ##0 o_pre_div == $past(wr_data[`PRE_MSB:`PRE_LSB], 2))
    else $error("pre divider does not follow write");
  AST_PUMP_DET: assert property (
    s_wr(`OFS_PUMP_DET) |-> s_settle
      ##0 (o_pump_enable == $past(wr_data[`BIT_PUMP_EN], 2)
      && o_detector_mode_sel == $past(wr_data[`DET_MSB:`DET_LSB], 2)))
    else $error("pump or detector mode does not follow write");
  AST_ACAL: assert property (
    s_wr(`OFS_MAIN_CTRL) ##0 !o_vco_amp_override
      |-> s_settle ##0 o_amp_cal_run == $past(wr_data[`BIT_AMP_CAL_ENABLE], 2))
    else $error("amplitude calibration enable not followed");
  AST_AMP_VALUE: assert property (
    s_wr(`OFS_AMP_VALUE) |-> s_settle
      ##0 o_vco_amp_value == $past(wr_data[`AMPV_MSB:`AMPV_LSB], 2))
    else $error("amplitude value does not follow write");
  AST_HOLD: assert property (
    (!wr_stb)[*3] |-> $stable(o_pre_div) && $stable(o_ref_multiplier)
      && $stable(o_pump_enable))
    else $error("control level changed without a write");

  // Further checks on levels, pulses and the readback line
  // Override and calibration never both own the amplitude
  AST_ACAL_EXCLUSIVE: assert property (
    o_vco_amp_override |-> !o_amp_cal_run)
    else $error("amplitude calibration running under override");

  // Clearing the override takes the override level low two edges after commit
  AST_AMP_OVR_CLEAR: assert property (
    s_wr(`OFS_VCO_OVR) ##0 !wr_data[`BIT_AMP_OVR] |-> s_settle
      ##0 !o_vco_amp_override)
    else $error("amplitude override did not clear");

  // Cap-bank override level follows its bit
  AST_CAP_OVR_LEVEL: assert property (
    s_wr(`OFS_VCO_OVR) |-> s_settle
      ##0 o_cap_bank_override == $past(wr_data[`BIT_CAP_OVR], 2))
    else $error("cap-bank override does not follow write");

  // Calibration enable level follows its bit
  AST_FREQ_CAL_ENABLE_LEVEL: assert property (
    s_wr(`OFS_MAIN_CTRL) |-> s_settle
      ##0 o_freq_cal_enable == $past(wr_data[`BIT_FREQ_CAL_ENABLE], 2))
    else $error("calibration enable does not follow write");

  // A launch pulse only ever follows a committed write of the bit
  AST_FCAL_CAUSE: assert property (
    o_freq_cal_start |-> $past(wr_stb) && $past(addr) == `OFS_MAIN_CTRL
      && $past(wr_data[`BIT_FREQ_CAL_ENABLE]))
    else $error("calibration launched without a write");

  // Remaining levels also stand between writes
  AST_HOLD_REST: assert property (
    (!wr_stb)[*3] |-> $stable(o_vco_amp_override)
      && $stable(o_cap_bank_override) && $stable(o_vco_amp_value)
      && $stable(o_ref_doubler_enable) && $stable(o_ref_path_enable)
      && $stable(o_post_div) && $stable(o_detector_mode_sel)
      && $stable(o_freq_cal_enable) && $stable(o_amp_cal_run))
    else $error("held level changed without a write");

  // Readback line rests low once a frame is over
  AST_SDO_IDLE: assert property (
    i_cs_n[*3] |-> !o_sdo)
    else $error("readback line active outside a frame");

  // First edge after reset shows the documented reset levels
  AST_RESET_LEVELS: assert property (
    $past(i_reset) |-> o_ref_path_enable && !o_ref_doubler_enable
      && o_post_div == 8'h01 && o_pre_div == 12'h001
      && o_vco_amp_value == 9'h12C
      && !o_vco_amp_override && !o_cap_bank_override)
    else $error("level after reset differs from its reset value");

  // Single-detector code reaches the output unchanged
  AST_DET_SINGLE: assert property (
    s_wr(`OFS_PUMP_DET) ##0 wr_data[`DET_MSB:`DET_LSB] == 2'h3
      |-> s_settle ##0 o_detector_mode_sel == 2'h3)
    else $error("single-detector code lost");

  // Pump switches off two edges after a write that clears its bit
  AST_PUMP_OFF: assert property (
    s_wr(`OFS_PUMP_DET) ##0 !wr_data[`BIT_PUMP_EN] |-> s_settle
      ##0 !o_pump_enable)
    else $error("charge pump not switched off");
endmodule
`default_nettype wire

//--- tb/serial_host_model.sv
// Host controller model that drives serial programming frames
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output var  logic o_sck,
  output var  logic o_cs_n,
  output var  logic o_sdi
);
  // Serial clock stands low and select high outside frames
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // One frame; half sets the rate, nbits below 24 cuts the frame short
  task automatic xfer(input logic rd, input logic [6:0] adr,
                      input logic [15:0] wd, input int nbits,
                      input int half, output logic [15:0] rdat);
    logic [23:0] f;
    f = {rd, adr, wd};
    rdat = 16'h0000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < nbits; i++)
    begin
      // Data moves only while the serial clock is low
      o_sdi <= f[23-i];
      repeat (half) @(posedge i_clk);
      // Readback bit was launched at the previous fall
      if (i >= 8)
        rdat[23-i] = i_sdo;
      o_sck <= 1'b1;
      repeat (half) @(posedge i_clk);
      o_sck <= 1'b0;
      @(posedge i_clk);
    end
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released data line shows the inverse of its last bit
    o_sdi <= ~o_sdi;
    // Gap keeps select high well over two cycles between frames
    repeat (4) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/synth_ref_path_vco_override_regs_tb_top.sv
// Self-checking bench for the reference path and VCO override registers
`timescale 1ns/100ps
`default_nettype none
`include "synth_cfg_params.svh"
module synth_ref_path_vco_override_regs_tb_top
  import synth_cfg_pkg::*;
;
  logic        i_clk;
  logic        i_reset;
  logic        sck;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        amp_ovr;
  logic        amp_run;
  logic [8:0]  amp_val;
  logic        cap_ovr;
  logic        freq_cal_enable;
  logic        fcal_go;
  logic        dbl;
  logic        ref_en;
  logic [4:0]  ref_multiplier;
  logic [7:0]  post;
  logic [11:0] pre;
  logic        pump;
  logic [1:0]  det;
  int          errors    = 0;
  int          tests_run = 0;
  int          seed      = 32'h94fd;
  int          fcal_cnt  = 0;
  int          c;
  int          adrs [7]  = '{8, 9, 10, 11, 12, 13, 19};
  reg_word_t   mdl [int];
  reg_word_t   rst_w [int];
  reg_word_t   rd_w;

  synth_ref_path_vco_override_regs synth_ref_path_vco_override_regs_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_sck(sck), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_vco_amp_override(amp_ovr),
    .o_amp_cal_run(amp_run), .o_vco_amp_value(amp_val),
    .o_cap_bank_override(cap_ovr), .o_freq_cal_enable(freq_cal_enable),
    .o_freq_cal_start(fcal_go), .o_ref_doubler_enable(dbl),
    .o_ref_path_enable(ref_en), .o_ref_multiplier(ref_multiplier),
    .o_post_div(post), .o_pre_div(pre), .o_pump_enable(pump),
    .o_detector_mode_sel(det));
  serial_host_model serial_host_model_i (
    .i_clk(i_clk), .i_sdo(sdo), .o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi));

  // 200 MHz clock
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;
  // Counts cycles of the calibration start pulse
  always @(posedge i_clk)
    if (fcal_go === 1'b1)
      fcal_cnt <= fcal_cnt + 1;

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Control levels against the model words
  task automatic check_outputs();
    chk("amp_ovr", mdl[8][13], amp_ovr);
    chk("amp_run", mdl[0][4] & ~mdl[8][13], amp_run);
    chk("amp_val", mdl[19][11:3], amp_val);
    chk("cap_ovr", mdl[8][10], cap_ovr);
    chk("freq_cal_enable", mdl[0][3], freq_cal_enable);
    chk("dbl", mdl[9][11], dbl);
    chk("ref_en", mdl[9][9], ref_en);
    chk("ref_multiplier", mdl[10][11:7], ref_multiplier);
    chk("post", mdl[11][11:4], post);
    chk("pre", mdl[12][11:0], pre);
    chk("pump", mdl[13][14], pump);
    chk("det", mdl[13][1:0], det);
    chk("sdo_idle", 16'h0000, sdo);
  endtask
  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    mdl = rst_w;
    @(posedge i_clk);
  endtask
  // Write frame; unmapped offsets leave the model alone
  task automatic wr(int a, reg_word_t d, int half);
    serial_host_model_i.xfer(1'b0, 7'(a), d, 24, half, rd_w);
    if (mdl.exists(a))
      mdl[a] = d;
    repeat (6) @(posedge i_clk);
  endtask
  task automatic rd_chk(int a);
    serial_host_model_i.xfer(1'b1, 7'(a), 16'($random(seed)), 24, 5, rd_w);
    chk("readback", mdl.exists(a) ? mdl[a] : 16'h0000, rd_w);
  endtask
  // Legal random word; unnamed bits keep the default pattern
  function automatic reg_word_t rand_word(int a);
    logic [31:0] r;
    reg_word_t   m;
    reg_word_t   f;
    r = $random(seed);
    case (a)
      8:  m = 16'h2400;
      9:  m = 16'h0A00;
      10: m = 16'h0F80;
      11: m = 16'h0FF0;
      12: m = 16'h0FFF;
      13: m = 16'h4003;
      default: m = 16'h0FF8;
    endcase
    f = r[15:0] & m;
    if (a == 10)
      f = {4'h0, 5'(4 + r[0]), 7'h00};
    if (a == 13)
      f = {1'b0, r[14], 12'h000, {2{r[1]}}};
    if (a == 19)
      f = {4'h0, 9'(250 + r % 201), 3'h0};
    return (rst_w[a] & ~m) | f;
  endfunction

  // Watchdog well beyond the expected run time
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end

  initial
  begin
    i_reset = 1'b1;
    rst_w[0] = `RST_MAIN_CTRL;
    rst_w[8] = `RST_VCO_OVR;
    rst_w[9] = `RST_REF_PATH;
    rst_w[10] = `RST_REF_REF_MULTIPLIER;
    rst_w[11] = `RST_POST_DIV;
    rst_w[12] = `RST_PRE_DIV;
    rst_w[13] = `RST_PUMP_DET;
    rst_w[19] = `RST_AMP_VALUE;
    do_reset();
    check_outputs();
    foreach (adrs[k])
      rd_chk(adrs[k]);
    rd_chk(5);
    // Random traffic at prompt and slow serial rates
    for (int n = 0; n < 16; n++)
    begin
      c = adrs[$unsigned($random(seed)) % 7];
      wr(c, rand_word(c), 2 + 3 * (n % 2));
      check_outputs();
    end
    foreach (adrs[k])
      rd_chk(adrs[k]);
    // Short frame and unmapped write change nothing
    serial_host_model_i.xfer(1'b0, 7'h0C, 16'h0ABC, 20, 2, rd_w);
    wr(5, 16'h1234, 2);
    check_outputs();
    rd_chk(12);
    rd_chk(5);
    // Calibration launch is a single one-cycle pulse
    wr(8, 16'h0000, 2);
    c = fcal_cnt;
    wr(0, rst_w[0] | 16'h0018, 2);
    chk("fcal_pulse", 16'(c + 1), 16'(fcal_cnt));
    // Both overrides on: no calibration, amp cal held off
    wr(8, 16'h2400, 5);
    c = fcal_cnt;
    wr(0, rst_w[0] | 16'h0018, 2);
    chk("fcal_skip", 16'(c), 16'(fcal_cnt));
    check_outputs();
    // Reset again in mid-run
    do_reset();
    check_outputs();
    foreach (adrs[k])
      rd_chk(adrs[k]);
    complete_run();
  end
endmodule
`default_nettype wire
